// file: design/irq_map_pkg.sv
/*
  constants for the interrupt vector map: request count, vector table
  layout, level field widths and reset values.
  assumes one system clock and an active low asynchronous reset.
*/
package irq_map_pkg;
  localparam int         NUM_REQ       = 24;
  localparam int         REQ_IDX_W     = 5;
  localparam int         LEVEL_W       = 2;
  localparam int         ADDR_W        = 16;
  localparam int         LVL_REG_W     = 8;
  localparam int         LVL_REG_CNT   = 6;
  // vector of request n: upper byte at top - 2n, lower byte one above
  localparam logic [15:0] VEC_TOP      = 16'hfffa;
  localparam logic [7:0]  LVL_REG_RST  = 8'hff;
  localparam logic [2:0]  LVL_REG_IDX_W_DUMMY = 3'h0;
  localparam logic [4:0]  REQ_FIVE     = 5'h05;
  localparam logic [4:0]  REQ_SIX      = 5'h06;
  localparam logic [4:0]  REQ_TWELVE   = 5'h0c;
  localparam logic [4:0]  REQ_THIRTEEN = 5'h0d;
  localparam logic [1:0]  LEVEL_LOWEST = 2'h3;
endpackage

// file: design/irq_level_store.sv
/*
  level setting store: six 8-bit registers, four 2-bit fields each,
  with registered read data.
  assumes writes and reads come from the core, synchronous to the clock.
*/
module irq_level_store
  import irq_map_pkg::*;
(
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst_b,
  input  wire logic                 i_wr_en,
  input  wire logic [2:0]           i_addr,
  input  wire logic [LVL_REG_W-1:0] i_wr_data,
  output logic [LVL_REG_W-1:0]      o_rd_data,
  output logic [NUM_REQ*LEVEL_W-1:0] o_levels
);
  logic [LVL_REG_W-1:0] mem_ff [LVL_REG_CNT];
  logic [LVL_REG_W-1:0] rd_ff;
  wire                  addr_ok = i_addr < 3'(LVL_REG_CNT);

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int k = 0; k < LVL_REG_CNT; k++) begin
        mem_ff[k] <= LVL_REG_RST;
      end
      rd_ff <= '0;
    end else begin
      if (i_wr_en && addr_ok) begin
        mem_ff[i_addr] <= i_wr_data;
      end
      rd_ff <= addr_ok ? mem_ff[i_addr] : '0;
    end
  end

  assign o_rd_data = rd_ff;

  genvar g;
  generate
    for (g = 0; g < LVL_REG_CNT; g++) begin : g_flat
      assign o_levels[g*LVL_REG_W +: LVL_REG_W] = mem_ff[g];
    end
  endgenerate
endmodule

// file: design/interrupt_vector_map.sv
/*
  interrupt vector map: peripheral requests are gathered, each given its
  programmed level, and the winning request's vector addresses and level
  are presented to the core.
  assumes request inputs are levels held by the peripherals until served,
  synchronous to i_clk_sys.
*/
// =====================================================================
// Summary of operation
// - The compound timer lower half raises request five, vector upper byte at fff0, level field five.
// - The compound timer upper half raises request six, vector at ffee/ffef, level field six.
// - The pulse generator upper channel raises request twelve, vector at ffe2/ffe3, level field twelve.
// - The pulse generator lower channel raises request thirteen, vector at ffe0/ffe1, level field thirteen.
// - Level setting registers are read/write and reset to all ones.
module interrupt_vector_map
  import irq_map_pkg::*;
(
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst_b,
  input  wire logic [NUM_REQ-1:0] i_req,
  input  wire logic               i_lvl_wr,
  input  wire logic [2:0]         i_lvl_addr,
  input  wire logic [7:0]         i_lvl_wdata,
  output logic [7:0]              o_lvl_rdata,
  output logic                    o_irq_valid,
  output logic [REQ_IDX_W-1:0]    o_irq_num,
  output logic [LEVEL_W-1:0]      o_irq_level,
  output logic [ADDR_W-1:0]       o_vec_upper,
  output logic [ADDR_W-1:0]       o_vec_lower
);
  // =====================================================================
  // level store
  logic [NUM_REQ*LEVEL_W-1:0] levels;

  irq_level_store u_store (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_wr_en   (i_lvl_wr),
    .i_addr    (i_lvl_addr),
    .i_wr_data (i_lvl_wdata),
    .o_rd_data (o_lvl_rdata),
    .o_levels  (levels)
  );

  // =====================================================================
  // vector address of a request; the table runs downward two per entry
  function automatic logic [ADDR_W-1:0] vec_upper(
    input logic [REQ_IDX_W-1:0] n);
    vec_upper = VEC_TOP - {10'h000, n, 1'b0};
  endfunction

  // =====================================================================
  // level field of one request out of the flattened store; used by the
  // arbiter and by the checks, so both read the same field layout
  function automatic logic [LEVEL_W-1:0] lvl_of(
    input logic [NUM_REQ*LEVEL_W-1:0] all,
    input logic [REQ_IDX_W-1:0]       n);
    lvl_of = all[n*LEVEL_W +: LEVEL_W];
  endfunction

  // =====================================================================
  // arbitration: lower level value is more urgent; scanning from the top
  // down lets equal levels fall to the lowest number
  logic                 win_any;
  logic [REQ_IDX_W-1:0] win_idx;
  logic [LEVEL_W-1:0]   win_lvl;

  always_comb begin
    win_any = 1'b0;
    win_idx = '0;
    win_lvl = LEVEL_LOWEST;
    for (int k = NUM_REQ-1; k >= 0; k--) begin
      if (i_req[k] &&
          (!win_any || lvl_of(levels, REQ_IDX_W'(k)) <= win_lvl)) begin
        win_any = 1'b1;
        win_idx = REQ_IDX_W'(k);
        win_lvl = lvl_of(levels, REQ_IDX_W'(k));
      end
    end
  end

  wire [ADDR_W-1:0] nxt_vec_upper = vec_upper(win_idx);

  // =====================================================================
  // registered answer to the core
  logic                 valid_ff;
  logic [REQ_IDX_W-1:0] num_ff;
  logic [LEVEL_W-1:0]   lvl_ff;
  logic [ADDR_W-1:0]    vec_ff;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      valid_ff <= 1'b0;
      num_ff   <= '0;
      lvl_ff   <= LEVEL_LOWEST;
      vec_ff   <= VEC_TOP;
    end else begin
      valid_ff <= win_any;
      num_ff   <= win_idx;
      lvl_ff   <= win_lvl;
      vec_ff   <= nxt_vec_upper;
    end
  end

  assign o_irq_valid = valid_ff;
  assign o_irq_num   = num_ff;
  assign o_irq_level = lvl_ff;
  assign o_vec_upper = vec_ff;
  assign o_vec_lower = vec_ff + 16'h0001;

  // =====================================================================
  // check helpers: the requests and levels the answer was built from.
  // a copy is kept rather than $past of an indexed term, because the
  // index itself (the winner) only exists one cycle later
  logic [NUM_REQ-1:0]         req_q_ff;
  logic [NUM_REQ*LEVEL_W-1:0] lvl_q_ff;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      req_q_ff <= '0;
      lvl_q_ff <= '1;
    end else begin
      req_q_ff <= i_req;
      lvl_q_ff <= levels;
    end
  end

  // =====================================================================
  // fixed sources: vector bytes and level field of each named request
  timer_low_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    valid_ff && num_ff == REQ_FIVE |-> vec_ff == 16'hfff0)
    else $error("request five vector wrong");
  timer_low_lo_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    valid_ff && num_ff == REQ_FIVE |-> o_vec_lower == 16'hfff1)
    else $error("request five lower vector wrong");
  timer_low_lvl_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    valid_ff && num_ff == REQ_FIVE |-> lvl_ff == lvl_of(lvl_q_ff, REQ_FIVE))
    else $error("request five level field wrong");
  timer_high_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    valid_ff && num_ff == REQ_SIX |-> vec_ff == 16'hffee)
    else $error("request six vector wrong");
  timer_high_lo_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    valid_ff && num_ff == REQ_SIX |-> o_vec_lower == 16'hffef)
    else $error("request six lower vector wrong");
  timer_high_lvl_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    valid_ff && num_ff == REQ_SIX |-> lvl_ff == lvl_of(lvl_q_ff, REQ_SIX))
    else $error("request six level field wrong");
  pulse_up_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    valid_ff && num_ff == REQ_TWELVE |-> vec_ff == 16'hffe2)
    else $error("request twelve vector wrong");
  pulse_up_lo_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    valid_ff && num_ff == REQ_TWELVE |-> o_vec_lower == 16'hffe3)
    else $error("request twelve lower vector wrong");
  pulse_up_lvl_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    valid_ff && num_ff == REQ_TWELVE |->
      lvl_ff == lvl_of(lvl_q_ff, REQ_TWELVE))
    else $error("request twelve level field wrong");
  pulse_low_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    valid_ff && num_ff == REQ_THIRTEEN |-> vec_ff == 16'hffe0)
    else $error("request thirteen vector wrong");
  pulse_low_lo_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    valid_ff && num_ff == REQ_THIRTEEN |-> o_vec_lower == 16'hffe1)
    else $error("request thirteen lower vector wrong");
  pulse_low_lvl_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    valid_ff && num_ff == REQ_THIRTEEN |->
      lvl_ff == lvl_of(lvl_q_ff, REQ_THIRTEEN))
    else $error("request thirteen level field wrong");

  // =====================================================================
  // arbitration outcome
  win_pending_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    req_q_ff != '0 |-> valid_ff && req_q_ff[num_ff])
    else $error("winner was not pending");
  idle_quiet_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    req_q_ff == '0 |-> !valid_ff)
    else $error("valid without any request");
  tie_break_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    valid_ff && num_ff != '0 |->
      !(req_q_ff[0] && lvl_of(lvl_q_ff, '0) <= lvl_ff))
    else $error("request zero lost a tie");

  // every pending request is held against the winner, two checks apiece
  genvar g;
  generate
    for (g = 0; g < NUM_REQ; g++) begin : g_order
      best_level_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        req_q_ff[g] |-> lvl_ff <= lvl_of(lvl_q_ff, REQ_IDX_W'(g)))
        else $error("winner level not the most urgent");
      low_number_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        req_q_ff[g] && lvl_of(lvl_q_ff, REQ_IDX_W'(g)) == lvl_ff |->
          num_ff <= REQ_IDX_W'(g))
        else $error("equal level lost to a higher number");
    end
  endgenerate

  // =====================================================================
  // level store
  level_reset_a: assert property (
    @(posedge i_clk_sys)
    $rose(i_rst_b) |-> levels == '1)
    else $error("levels not all ones after reset");
endmodule

// file: verif/vector_fetch_model.sv
/*
  core side model: forms the vector address the core would fetch.
  assumes the vector map outputs are registered on the system clock.
*/
module vector_fetch_model (
  input  wire logic        i_irq_valid,
  input  wire logic [15:0] i_vec_upper,
  output logic [15:0]      o_fetch_addr
);
  // no fetch without a request: show the inverted upper vector, not stale data
  assign o_fetch_addr = i_irq_valid ? i_vec_upper : ~i_vec_upper;
endmodule

// file: verif/tb_interrupt_vector_map.sv
/*
  testbench for the interrupt vector map and the core fetch model.
  assumes the design package and one 10 MHz clock.
*/
module tb_interrupt_vector_map
  import irq_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst_b = 0, lvl_wr = 0, irq_valid;
  logic [23:0] req = '0;
  logic [2:0]  lvl_addr = '0;
  logic [7:0]  lvl_wdata = '0, lvl_rdata;
  logic [4:0]  irq_num;
  logic [1:0]  irq_level;
  logic [15:0] vec_upper, vec_lower, fetch_addr;
  int          n_fail = 0, n_checks = 0;
  always #50 clk_sys = ~clk_sys;
  interrupt_vector_map u_interrupt_vector_map (.i_clk_sys(clk_sys),
    .i_rst_b(rst_b), .i_req(req), .i_lvl_wr(lvl_wr),
    .i_lvl_addr(lvl_addr), .i_lvl_wdata(lvl_wdata),
    .o_lvl_rdata(lvl_rdata), .o_irq_valid(irq_valid),
    .o_irq_num(irq_num), .o_irq_level(irq_level),
    .o_vec_upper(vec_upper), .o_vec_lower(vec_lower));
  vector_fetch_model u_vector_fetch_model (.i_irq_valid(irq_valid),
    .i_vec_upper(vec_upper), .o_fetch_addr(fetch_addr));
  // ====================================================================
  // helpers
  task chk(input string what, input logic [15:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task finish_test;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task drive_req(input logic [23:0] v);
    @(posedge clk_sys) req <= v;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task check_win(input logic [4:0] n, input logic [15:0] up,
                 input logic [1:0] lv);
    chk("valid", 16'h1, {15'h0, irq_valid});
    chk("num", {11'h0, n}, {11'h0, irq_num});
    chk("level", {14'h0, lv}, {14'h0, irq_level});
    chk("upper", up, vec_upper);
    chk("lower", up + 16'h1, vec_lower);
    chk("fetch", up, fetch_addr);
  endtask
  task write_lvl(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys) {lvl_wr, lvl_addr, lvl_wdata} <= {1'b1, a, d};
    @(posedge clk_sys) lvl_wr <= 1'b0;
  endtask
  task read_lvl(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys) lvl_addr <= a;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("rdata", {8'h0, e}, {8'h0, lvl_rdata});
  endtask
  // ====================================================================
  // scenarios
  task t_reset_levels;
    for (int r = 0; r < 6; r++) read_lvl(3'(r), 8'hff);
    read_lvl(3'h6, 8'h00);
  endtask
  task t_timer;
    drive_req(24'h000020);
    check_win(5'h05, 16'hfff0, 2'h3);
    drive_req(24'h000040);
    check_win(5'h06, 16'hffee, 2'h3);
  endtask
  task t_pulse_pair;
    drive_req(24'h003000);
    check_win(5'h0c, 16'hffe2, 2'h3);
    drive_req(24'h002000);
    check_win(5'h0d, 16'hffe0, 2'h3);
  endtask
  task t_level_change;
    write_lvl(3'h3, 8'hf3);
    read_lvl(3'h3, 8'hf3);
    drive_req(24'h003000);
    check_win(5'h0d, 16'hffe0, 2'h0);
    drive_req(24'h000000);
    chk("idle", 16'h0, {15'h0, irq_valid});
  endtask
  task t_zero_first;
    drive_req(24'h800001);
    check_win(5'h00, 16'hfffa, 2'h3);
    drive_req(24'h002001);
    check_win(5'h0d, 16'hffe0, 2'h0);
    drive_req(24'h000000);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset_levels();
    t_timer();
    t_pulse_pair();
    t_level_change();
    t_zero_first();
    finish_test();
  end
  // about 46 cycles of tests; allow far more before calling it a hang
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
endmodule
